// >>> core/pdos_map.svh
// Address map, field layout, reset values, state codes and timing of the
// power-down order sequencer. Definitions only; included by bare name.
`ifndef PDOS_MAP_SVH
`define PDOS_MAP_SVH

`define PDOS_NUM_REGS        7
`define PDOS_ADDR_BUCK_ONE   8'h5f
`define PDOS_ADDR_BUCK_TWO   8'h60
`define PDOS_ADDR_BUCK_THREE 8'h61
`define PDOS_ADDR_LIN_ONE    8'h62
`define PDOS_ADDR_LIN_TWO    8'h63
`define PDOS_ADDR_LIN_THREE  8'h64
`define PDOS_ADDR_MEM_REF    8'h65
`define PDOS_ADDR_STATE      8'h67

`define PDOS_FIELD_MSB       2
`define PDOS_FIELD_LSB       0
`define PDOS_ORDER_RESET     3'h0
`define PDOS_ORDER_TOP       3'h7

`define PDOS_ST_WAIT         6'h00
`define PDOS_ST_RUN          6'h0c
`define PDOS_ST_STANDBY      6'h0d
`define PDOS_ST_SLEEP        6'h0e
`define PDOS_ST_REGS_OFF     6'h2b

`define PDOS_CLK_PERIOD_NS   25
`define PDOS_STEP_GAP_NS     1000
`define PDOS_STEP_CYCLES     ((`PDOS_STEP_GAP_NS + `PDOS_CLK_PERIOD_NS - 1) / `PDOS_CLK_PERIOD_NS)

`endif

// >>> core/pdos_pkg.sv
// Types shared by the power-down order sequencer files.
// Assumes pdos_map.svh supplies all numeric constants.
package pdos_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pdos_bus_req_t;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_STEP,
        SEQ_WAIT
    } pdos_seq_state_t;

endpackage

// >>> core/pdos_order_pick.sv
// Selects the regulators whose order field equals the current level.
// Assumes fields packed three bits per regulator, regulator 0 lowest.
`timescale 1ns/1ps
`include "pdos_map.svh"

module pdos_order_pick (
    input  wire logic [3*`PDOS_NUM_REGS-1:0] orders,
    input  wire logic [2:0]                  level,
    output logic      [`PDOS_NUM_REGS-1:0]   matchMask,
    output logic                             allZero
);

    genvar gi;
    generate
        for (gi = 0; gi < `PDOS_NUM_REGS; gi++) begin : g_match
            assign matchMask[gi] = (orders[3*gi +: 3] == level);
        end
    endgenerate

    assign allZero = (orders == '0);

endmodule // pdos_order_pick

// >>> core/pdos_sequencer.sv
// Power-down order registers and the descending power-down sequencer.
// Assumes a register access port and machine state from same-clock logic,
// and fused power-up orders stable from reset release onward.
//
// Function
// - Seven three-bit order fields, bits 2:0
// - First clock after reset release loads fields from fused power-up order
// - Switch off one level at a time, descending
// - Host writes accepted only in system-on states
// - Power-up order never changed by writes
// - All fields zero: everything off at once
// - Second, third linear, memory reference at 0x63-0x65
// - Report six-bit machine state code
`timescale 1ns/1ps
`include "pdos_map.svh"

module pdos_sequencer (
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    input  wire pdos_pkg::pdos_bus_req_t       busReq,
    output logic      [7:0]                    busRdata,
    input  wire logic [5:0]                    machineState,
    input  wire logic [3*`PDOS_NUM_REGS-1:0]   fusedUpOrder,
    input  wire logic                          powerDownStart,
    input  wire logic                          seqRestart,
    output logic      [`PDOS_NUM_REGS-1:0]     regOff,
    output logic                               powerDownBusy,
    output logic                               powerDownDone
);

    localparam int STEP_GAP = `PDOS_STEP_CYCLES;

    // Returns {hit, index} for an order register address
    function automatic logic [3:0] addrToIndex(input logic [7:0] a);
        logic [3:0] r;
        r = 4'h0;
        unique case (a)
            `PDOS_ADDR_BUCK_ONE:   r = 4'h8;
            `PDOS_ADDR_BUCK_TWO:   r = 4'h9;
            `PDOS_ADDR_BUCK_THREE: r = 4'ha;
            `PDOS_ADDR_LIN_ONE:    r = 4'hb;
            `PDOS_ADDR_LIN_TWO:    r = 4'hc;
            `PDOS_ADDR_LIN_THREE:  r = 4'hd;
            `PDOS_ADDR_MEM_REF:    r = 4'he;
            default:               r = 4'h0;
        endcase
        return r;
    endfunction

    function automatic logic isSystemOn(input logic [5:0] s);
        return (s == `PDOS_ST_RUN) || (s == `PDOS_ST_STANDBY) || (s == `PDOS_ST_SLEEP);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Order registers

    logic [2:0]                      orderFf [`PDOS_NUM_REGS];
    logic [2:0]                      nxtOrder [`PDOS_NUM_REGS];
    logic [3*`PDOS_NUM_REGS-1:0]     orderPacked;
    logic                            loadedFf;
    logic                            nxtLoaded;
    logic [3:0]                      wrDec;
    logic [3:0]                      rdDec;
    logic                            writeTake;
    logic [2:0]                      writeIdx;
    logic [7:0]                      rdataFf;
    logic [7:0]                      nxtRdata;

    assign wrDec     = addrToIndex(busReq.addr);
    assign rdDec     = wrDec;
    assign writeIdx  = wrDec[2:0];
    assign writeTake = busReq.wr && wrDec[3] && loadedFf
                       && isSystemOn(machineState);

    genvar gi;
    generate
        for (gi = 0; gi < `PDOS_NUM_REGS; gi++) begin : g_pack
            assign orderPacked[3*gi +: 3] = orderFf[gi];
        end
    endgenerate

    // Fuse values are caught on the first clock after release, since an
    // asynchronous reset may only load constants.
    always_comb begin
        nxtLoaded = 1'b1;
        for (int i = 0; i < `PDOS_NUM_REGS; i++) begin
            nxtOrder[i] = orderFf[i];
            if (!loadedFf) begin
                nxtOrder[i] = fusedUpOrder[3*i +: 3];
            end else if (writeTake && (writeIdx == 3'(i))) begin
                nxtOrder[i] = busReq.wdata[`PDOS_FIELD_MSB:`PDOS_FIELD_LSB];
            end
        end
    end

    always_comb begin
        nxtRdata = rdataFf;
        if (busReq.rd) begin
            if (rdDec[3]) begin
                nxtRdata = {5'h00, orderFf[rdDec[2:0]]};
            end else if (busReq.addr == `PDOS_ADDR_STATE) begin
                nxtRdata = {2'h0, machineState};
            end else begin
                nxtRdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            loadedFf <= 1'b0;
            rdataFf  <= 8'h00;
            for (int i = 0; i < `PDOS_NUM_REGS; i++) begin
                orderFf[i] <= `PDOS_ORDER_RESET;
            end
        end else begin
            loadedFf <= nxtLoaded;
            rdataFf  <= nxtRdata;
            for (int i = 0; i < `PDOS_NUM_REGS; i++) begin
                orderFf[i] <= nxtOrder[i];
            end
        end
    end

    assign busRdata = rdataFf;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    pdos_pkg::pdos_seq_state_t       seqFf;
    pdos_pkg::pdos_seq_state_t       nxtSeq;
    logic [2:0]                      levelFf;
    logic [2:0]                      nxtLevel;
    logic [7:0]                      waitFf;
    logic [7:0]                      nxtWait;
    logic [`PDOS_NUM_REGS-1:0]       offFf;
    logic [`PDOS_NUM_REGS-1:0]       nxtOff;
    logic                            doneFf;
    logic                            nxtDone;
    logic [`PDOS_NUM_REGS-1:0]       matchMask;
    logic                            allZero;

    pdos_order_pick pdos_order_pick_inst (
        .orders    (orderPacked),
        .level     (levelFf),
        .matchMask (matchMask),
        .allZero   (allZero)
    );

    // Regulators sharing one level go off together; empty levels are
    // skipped without a gap, though each empty level still costs one cycle.
    always_comb begin
        nxtSeq   = seqFf;
        nxtLevel = levelFf;
        nxtWait  = waitFf;
        nxtOff   = offFf;
        nxtDone  = 1'b0;
        unique case (seqFf)
            pdos_pkg::SEQ_IDLE: begin
                if (powerDownStart && loadedFf) begin
                    if (allZero) begin
                        nxtOff  = '1;
                        nxtDone = 1'b1;
                    end else begin
                        nxtLevel = `PDOS_ORDER_TOP;
                        nxtSeq   = pdos_pkg::SEQ_STEP;
                    end
                end else if (seqRestart) begin
                    nxtOff = '0;
                end
            end
            pdos_pkg::SEQ_STEP: begin
                nxtOff = offFf | matchMask;
                if (levelFf == 3'h0) begin
                    nxtSeq  = pdos_pkg::SEQ_IDLE;
                    nxtDone = 1'b1;
                end else if (matchMask != '0) begin
                    nxtWait = 8'(STEP_GAP - 2);
                    nxtSeq  = pdos_pkg::SEQ_WAIT;
                end else begin
                    nxtLevel = levelFf - 3'h1;
                end
            end
            pdos_pkg::SEQ_WAIT: begin
                if (waitFf == 8'h00) begin
                    nxtLevel = levelFf - 3'h1;
                    nxtSeq   = pdos_pkg::SEQ_STEP;
                end else begin
                    nxtWait = waitFf - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            seqFf   <= pdos_pkg::SEQ_IDLE;
            levelFf <= 3'h0;
            waitFf  <= 8'h00;
            offFf   <= '0;
            doneFf  <= 1'b0;
        end else begin
            seqFf   <= nxtSeq;
            levelFf <= nxtLevel;
            waitFf  <= nxtWait;
            offFf   <= nxtOff;
            doneFf  <= nxtDone;
        end
    end

    assign regOff        = offFf;
    assign powerDownDone = doneFf;
    assign powerDownBusy = (seqFf != pdos_pkg::SEQ_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence offStep;
        (seqFf == pdos_pkg::SEQ_STEP) && (matchMask != '0) && (levelFf != 3'h0);
    endsequence

    sequence gapThenNext;
        (seqFf == pdos_pkg::SEQ_WAIT) ##(STEP_GAP - 1) (seqFf == pdos_pkg::SEQ_STEP);
    endsequence

    fuse_load_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(loadedFf) |-> orderPacked == $past(fusedUpOrder))
        else $error("order fields not loaded from fused power-up order");

    write_gate_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (busReq.wr && loadedFf && !isSystemOn(machineState)) |=> $stable(orderPacked))
        else $error("order field changed outside system-on state");

    write_take_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        writeTake |=> orderFf[$past(writeIdx)] == $past(busReq.wdata[2:0]))
        else $error("order field write not taken");

    field_hold_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (loadedFf && !writeTake) |=> $stable(orderPacked))
        else $error("order field changed without a register write");

    upper_zero_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (busReq.rd && rdDec[3]) |=> busRdata[7:3] == 5'h00)
        else $error("unused order bits read nonzero");

    state_read_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (busReq.rd && busReq.addr == `PDOS_ADDR_STATE)
        |=> busRdata == {2'h0, $past(machineState)})
        else $error("machine state readback wrong");

    bulk_off_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (seqFf == pdos_pkg::SEQ_IDLE && powerDownStart && loadedFf && allZero)
        |=> (regOff == '1) && powerDownDone && !powerDownBusy)
        else $error("all-zero orders did not switch everything off at once");

    level_off_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (seqFf == pdos_pkg::SEQ_STEP) |=> (regOff & ~$past(regOff)) == ($past(matchMask)
            & ~$past(regOff)))
        else $error("regulator switched off at the wrong level");

    step_gap_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        offStep |=> gapThenNext)
        else $error("gap between power-down levels wrong");

endmodule // pdos_sequencer

// >>> tb/pdos_host_model.sv
// Host processor model: issues register reads and writes on the access port.
// Assumes the bench calls access() one request at a time; strobes last one cycle.
`timescale 1ns/1ps
module pdos_host_model (
    input  wire logic           clk,
    output pdos_pkg::pdos_bus_req_t busReq
);
    initial busReq = '0;

    // Request is launched 1 ns after an edge so it never races the sampling edge
    task automatic access(input logic isWr, input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk) #1;
        busReq = '{wr: isWr, rd: !isWr, addr: addr, wdata: data};
        @(posedge clk) #1;
        busReq = '0;
    endtask
endmodule // pdos_host_model

// >>> tb/power_down_order_sequencer_tb.sv
// Self-checking bench for the power-down order sequencer.
// Assumes the host model drives the access port; the bench drives all else.
`timescale 1ns/1ps
`include "pdos_map.svh"
module power_down_order_sequencer_tb;
    localparam int N = `PDOS_NUM_REGS;
    logic                    clk = 1'b0;
    logic                    reset_n = 1'b0;
    logic                    powerDownStart = 1'b0;
    logic                    seqRestart = 1'b0;
    logic [5:0]              machineState = `PDOS_ST_RUN;
    logic [3*N-1:0]          fusedUpOrder = '0;
    logic [3*N-1:0]          orders = '0;
    logic [7:0]              busRdata;
    logic [7:0]              base = `PDOS_ADDR_BUCK_ONE;
    logic [N-1:0]            regOff;
    logic                    powerDownBusy;
    logic                    powerDownDone;
    logic [5:0]              stCodes [5] = '{`PDOS_ST_WAIT, `PDOS_ST_RUN,
                                 `PDOS_ST_STANDBY, `PDOS_ST_SLEEP, `PDOS_ST_REGS_OFF};
    pdos_pkg::pdos_bus_req_t busReq;
    int                      error_cnt = 0;
    int                      num_checks = 0;
    int                      cycles = 0;
    int                      seed = 32'hfc0f;

    pdos_host_model pdos_host_model_inst (.clk(clk), .busReq(busReq));

    pdos_sequencer pdos_sequencer_inst (
        .clk(clk), .reset_n(reset_n), .busReq(busReq), .busRdata(busRdata),
        .machineState(machineState), .fusedUpOrder(fusedUpOrder),
        .powerDownStart(powerDownStart), .seqRestart(seqRestart), .regOff(regOff),
        .powerDownBusy(powerDownBusy), .powerDownDone(powerDownDone)
    );

    always #12.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic cmp(input logic [15:0] exp, input logic [15:0] act);
        num_checks++;
        if (act !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t exp=%h act=%h", $time, exp, act);
        end
    endtask

    task automatic rdChk(input logic [7:0] addr, input logic [7:0] exp);
        pdos_host_model_inst.access(1'b0, addr, 8'h00);
        cmp({8'h00, exp}, {8'h00, busRdata});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] fld(input int i);
        return {5'h00, orders[3*i +: 3]};
    endfunction

    function automatic bit used(input int m);
        for (int i = 0; i < N; i++) begin
            if (orders[3*i +: 3] == m) return 1'b1;
        end
        return 1'b0;
    endfunction

    // Level 7 shows one cycle after start; each occupied level above adds
    // its settling gap of one step period less one cycle
    function automatic int lateAt(input int lvl);
        int k = 0;
        for (int m = 7; m > lvl; m--) begin
            if (used(m)) k++;
        end
        return 8 - lvl + (`PDOS_STEP_CYCLES - 1) * k;
    endfunction

    function automatic int offAt(input int i);
        return (orders == '0) ? 0 : lateAt(orders[3*i +: 3]);
    endfunction

    task automatic powerDown();
        int n = 0;
        logic [N-1:0] expOff;
        powerDownStart = 1'b1;
        @(posedge clk) #1;
        powerDownStart = 1'b0;
        while (powerDownDone !== 1'b1 && n < 400) begin
            @(posedge clk) #1;
            n++;
            // Restart and a second start while busy must both be ignored
            seqRestart = (n == 3);
            powerDownStart = (n == 3);
            for (int i = 0; i < N; i++) begin
                expOff[i] = (n >= offAt(i));
            end
            cmp({9'h000, expOff}, {9'h000, regOff});
        end
        cmp(16'h0001, {15'h0000, powerDownDone});
        cmp({9'h000, {N{1'b1}}}, {9'h000, regOff});
        cmp((orders == '0) ? 16'h0000 : 16'(lateAt(0)), 16'(n));
        @(posedge clk) #1;
        seqRestart = 1'b1;
        @(posedge clk) #1;
        seqRestart = 1'b0;
        cmp(16'h0000, {8'h00, powerDownBusy, regOff});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        for (int it = 0; it < 8; it++) begin
            r = $random(seed);
            @(posedge clk) #1;
            reset_n = 1'b0;
            fusedUpOrder = r[3*N-1:0];
            repeat (it == 0 ? 20 : 3) @(posedge clk);
            #1 reset_n = 1'b1;
            repeat (2) @(posedge clk);
            orders = fusedUpOrder;
            for (int i = 0; i < N; i++) rdChk(base + 8'(i), fld(i));
            for (int k = 0; k < 5; k++) begin
                machineState = stCodes[k];
                rdChk(`PDOS_ADDR_STATE, {2'h0, stCodes[k]});
                for (int i = 0; i < N; i++) begin
                    r = $random(seed);
                    pdos_host_model_inst.access(1'b1, base + 8'(i), r[7:0]);
                    if (k inside {[1:3]}) orders[3*i +: 3] = r[2:0];
                    rdChk(base + 8'(i), fld(i));
                end
            end
            pdos_host_model_inst.access(1'b1, `PDOS_ADDR_STATE, 8'hff);
            rdChk(`PDOS_ADDR_STATE, {2'h0, machineState});
            rdChk(8'h66, 8'h00);
            machineState = `PDOS_ST_RUN;
            r = $random(seed);
            // Corner orders in passes 1-3: all zero, all top level, single mid level
            orders = (it == 1) ? '0 : (it == 2) ? '1 : (it == 3) ? 21'h000002 : r[3*N-1:0];
            for (int i = 0; i < N; i++) begin
                pdos_host_model_inst.access(1'b1, base + 8'(i), {r[31:27], orders[3*i +: 3]});
            end
            powerDown();
        end
        stop_test();
    end
endmodule // power_down_order_sequencer_tb
